// File: dv/bccr_adc_model.sv
`timescale 1ns/10ps
// ========================================
// ADC and amp cal stand-in
module bccr_adc_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_slow,
  input  wire logic       i_conv_start,
  input  wire logic [2:0] i_amp_ctrl,
  output logic            o_conv_done = 1'b0,
  output logic            o_amp_done = 1'b0
);
  int cnt = 0;  // Cycles left
  // Slow mode lets commands land mid-scan
  always @(posedge i_core_clk) begin
    o_conv_done <= 1'b0;
    if (i_rst) begin
      cnt <= 0;
    end else if (i_conv_start) begin
      cnt <= i_slow ? 12 : 3;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_conv_done <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  // Trigger work takes one cycle
  always @(posedge i_core_clk) o_amp_done <= !i_rst && i_amp_ctrl[1] && !o_amp_done;
endmodule

// File: dv/bccr_config_regs_bench.sv
`timescale 1ns/10ps
// ========================================
// Register bank regression
module bccr_config_regs_bench;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, xst = 1'b0, slow = 1'b0, aev = 1'b1;
  logic [4:0] cmd = 5'h00;
  logic [15:0] wd = 16'h0000, rdd;
  logic [1:0] mode = 2'h0, pev = 2'h2;
  logic rv, aout, aoe, cst, busy, cdn, adn, rest, csl;
  logic [1:0][9:0] fdac;
  logic [1:0][7:0] chi, clo;
  logic [1:0] fcal, high_cal_request, low_cal_request, pout, poe;
  logic [6:0] hyst;
  logic [3:0] aen, win;
  logic [2:0] csel, actl;
  logic [5:0] slog = 6'h00;  // Last two selects
  logic [7:0] hwc [4] = '{8'h80, 8'h00, 8'h2a, 8'h15};  // Pin configs
  logic [5:0] hwe [4] = '{6'h3f, 6'h3b, 6'h17, 6'h01};  // Alarm out/oe, protect out/oe
  int fail_count = 0, checks_done = 0, nconv = 0, n0;
  initial forever #10 clk = ~clk;
  // Log launches
  always @(posedge clk) if (cst) begin
    nconv <= nconv + 1;
    slog <= {slog[2:0], csel};
  end
  bccr_config_regs bccr_config_regs_inst (
    .i_core_clk(clk), .i_rst(rst), .i_wr_en(we), .i_rd_en(re), .i_cmd(cmd), .i_wr_data(wd), .o_rd_data(rdd),
    .o_rd_valid(rv), .o_fine_dac(fdac), .o_fine_cal_start(fcal), .o_coarse_high(chi), .o_coarse_low(clo),
    .o_high_cal_start(high_cal_request), .o_low_cal_start(low_cal_request), .o_threshold_restore(rest), .o_alarm_comparator_sel(csl),
    .o_hysteresis_lsbs(hyst), .o_meas_alarm_en(aen), .o_meas_window_mode(win), .i_protect_eval(pev),
    .i_alarm_eval(aev), .o_protect_out(pout), .o_protect_oe(poe), .o_alarm_out(aout), .o_alarm_oe(aoe),
    .i_adc_clk_mode(mode), .i_ext_conv_start(xst), .i_conv_done(cdn), .o_conv_start(cst), .o_conv_sel(csel),
    .o_adc_busy(busy), .i_amp_cal_done(adn), .o_amp_cal_ctrl(actl));
  bccr_adc_model bccr_adc_model_inst (.i_core_clk(clk), .i_rst(rst), .i_slow(slow), .i_conv_start(cst),
    .i_amp_ctrl(actl), .o_conv_done(cdn), .o_amp_done(adn));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // Settle past the n-th edge
  task automatic after(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobe lasts one taken edge
  task automatic wr(input logic [4:0] c, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    cmd <= c;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // No valid is a mismatch
  task automatic rd(input logic [4:0] c, input logic [15:0] e);
    @(posedge clk);
    re <= 1'b1;
    cmd <= c;
    @(posedge clk);
    re <= 1'b0;
    #1;
    cmp("read", e, rv ? rdd : ~e);
  endtask
  task automatic wait_conv(input int n);
    for (int k = 0; k < 500 && nconv < n; k++) @(posedge clk);
    if (nconv < n) begin
      fail_count++;
      $display("FAIL conversions expected %0d seen %0d", n, nconv);
      stop_test();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(bccr_pkg::CMD_COARSE_LO_CH2, 16'h8000);
    rd(bccr_pkg::CMD_FINE_RB_CH1, 16'h0000);
    wr(bccr_pkg::CMD_FINE_BUF_CH1, 16'hffff);
    after(0);
    cmp("dac_cal", 16'h0000, {fcal, 4'h0, fdac[0]});
    rd(bccr_pkg::CMD_FINE_RB_CH1, 16'h03ff);
    wr(bccr_pkg::CMD_DAC_LOAD, 16'h0004);
    after(1);
    cmp("dac", 16'h03ff, 16'(fdac[0]));
    wr(bccr_pkg::CMD_FINE_BUF_CH1, 16'h0001);
    wr(bccr_pkg::CMD_DAC_LOAD, 16'h0000);
    after(1);
    cmp("dac", 16'h03ff, 16'(fdac[0]));
    wr(bccr_pkg::CMD_FINE_CAL_CH2, 16'h0123);
    after(0);
    cmp("cal", 16'h0002, 16'(fcal));
    wr(bccr_pkg::CMD_FINE_DIR_CH2, 16'hfd55);
    after(0);
    cmp("dac", 16'h0155, 16'(fdac[1]));
    rd(bccr_pkg::CMD_FINE_RB_CH2, 16'h0155);
    wr(bccr_pkg::CMD_COARSE_HI_CH1, 16'hffa5);
    rd(bccr_pkg::CMD_COARSE_HI_CH1, 16'h80a5);
    wr(bccr_pkg::CMD_COARSE_LO_CH2, 16'h0033);
    wr(bccr_pkg::CMD_DAC_LOAD, 16'h000a);
    after(1);
    cmp("coarse_cal", 16'h0004, 16'({high_cal_request, low_cal_request}));
    cmp("coarse", 16'h33a5, {clo[1], chi[0]});
    wr(bccr_pkg::CMD_ALARM_SW, 16'hfaaa);
    after(0);
    cmp("alarm_sw", 16'h02f0, 16'({rest, csl, aen, win}));
    rd(bccr_pkg::CMD_ALARM_SW, 16'h02aa);
    for (int i = 0; i < 4; i++) begin
      wr(bccr_pkg::CMD_ALARM_SW, 16'h0455 | 16'(i << 8));
      after(0);
      cmp("hyst", 16'(8 << i), 16'(hyst));
    end
    cmp("alarm_sw", 16'h010f, 16'({rest, csl, aen, win}));
    for (int i = 0; i < 4; i++) begin
      wr(bccr_pkg::CMD_ALARM_HW, {8'h00, hwc[i]});
      after(2);
      cmp("pins", 16'(hwe[i]), 16'({aout, aoe, pout, poe}));
    end
    wr(bccr_pkg::CMD_AMP_CAL, 16'h0007);
    after(3);
    cmp("amp_cal", 16'h0005, 16'(actl));
    slow <= 1'b1;
    wr(bccr_pkg::CMD_ADC_SCAN, 16'hf005);
    wait_conv(1);
    after(1);
    cmp("busy", 16'h0001, 16'(busy));
    after(40);
    cmp("scan", 16'h0202, {nconv[7:0], 2'b00, slog});
    n0 = nconv;
    wr(bccr_pkg::CMD_ADC_SCAN, 16'h0083);
    wait_conv(n0 + 2);
    after(1);
    cmp("busy", 16'h0000, 16'(busy));
    wait_conv(n0 + 3);
    wr(bccr_pkg::CMD_ADC_SCAN, 16'h0003);
    after(60);
    cmp("scan", 16'h0401, {nconv[7:0] - n0[7:0], 2'b00, slog});
    mode <= 2'h3;
    n0 = nconv;
    wr(bccr_pkg::CMD_ADC_SCAN, 16'h0081);
    @(posedge clk);
    xst <= 1'b1;
    @(posedge clk);
    xst <= 1'b0;
    wait_conv(n0 + 1);
    after(1);
    cmp("busy", 16'h0001, 16'(busy));
    after(60);
    cmp("scan", 16'h0001, 16'(nconv - n0));
    stop_test();
  end
endmodule

// File: dv/bccr_config_regs_properties.sv
`timescale 1ns/10ps
// ========================================
// Port checks
module bccr_config_regs_properties (
  input wire logic            i_core_clk,
  input wire logic            i_rst,
  input wire logic            i_wr_en,
  input wire logic            i_rd_en,
  input wire logic [4:0]      i_cmd,
  input wire logic [15:0]     i_wr_data,
  input wire logic            o_rd_valid,
  input wire logic [1:0][9:0] o_fine_dac,
  input wire logic [1:0]      o_fine_cal_start,
  input wire logic [1:0]      o_high_cal_start,
  input wire logic            o_threshold_restore,
  input wire logic            o_alarm_comparator_sel,
  input wire logic [6:0]      o_hysteresis_lsbs,
  input wire logic [3:0]      o_meas_alarm_en,
  input wire logic            o_conv_start
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Decoded host writes
  wire logic       sw = i_wr_en && i_cmd == bccr_pkg::CMD_ALARM_SW;
  wire logic       ld = i_wr_en && i_cmd == bccr_pkg::CMD_DAC_LOAD;
  wire logic       rs = sw && i_wr_data[11];
  wire logic       lh = ld && i_wr_data[1];
  wire logic [3:0] en = {i_wr_data[7], i_wr_data[5], i_wr_data[3], i_wr_data[1]};
  property p_rd; i_rd_en |=> o_rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_dir; i_wr_en && i_cmd == bccr_pkg::CMD_FINE_DIR_CH1 |=> o_fine_dac[0] == $past(i_wr_data[9:0]); endproperty
  a_dir: assert property (p_dir) else $error("direct write lost");
  // A load just before may still move it
  property p_buf; i_wr_en && i_cmd == bccr_pkg::CMD_FINE_BUF_CH1 && !$past(ld)
    |=> $stable(o_fine_dac[0]) && !o_fine_cal_start[0]; endproperty
  a_buf: assert property (p_buf) else $error("buffered write moved");
  property p_rs; o_threshold_restore == $past(rs); endproperty
  a_rs: assert property (p_rs) else $error("restore mismatch");
  property p_fld; sw |=> o_alarm_comparator_sel == $past(i_wr_data[10]) && o_meas_alarm_en == $past(en); endproperty
  a_fld: assert property (p_fld) else $error("alarm field");
  property p_hys; sw |=> o_hysteresis_lsbs == 7'h08 << $past(i_wr_data[9:8]); endproperty
  a_hys: assert property (p_hys) else $error("hyst mismatch");
  property p_cal; o_high_cal_start[0] |-> $past(lh) || $past(lh, 2); endproperty
  a_cal: assert property (p_cal) else $error("stray high cal");
  property p_cnv; o_conv_start |=> !o_conv_start; endproperty
  a_cnv: assert property (p_cnv) else $error("start not a pulse");
  c_dir: cover property (i_wr_en && i_cmd == bccr_pkg::CMD_FINE_DIR_CH1);
  c_cal: cover property (o_high_cal_start[0]);
  c_cnv: cover property (o_conv_start);
endmodule
bind bccr_config_regs bccr_config_regs_properties bccr_config_regs_properties_inst (.*);

// File: verilog/bccr_config_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Buffered fine write neither calibrates nor updates output
// [R2] Fine writes drop data bits 15 to 10
// [R3] Fine input registers reset to zero
// [R4] Fine read-back returns latest raw write
// [R5] Direct fine write copies to output immediately
// [R6] Bit 11 restores thresholds to power-on values
// [R7] Bit 10 picks comparator or interrupt alarm
// [R8] Two-bit hysteresis code: 8,16,32,64 LSBs
// [R9] Enable bits gate measurements onto alarm outputs
// [R10] Mode bits pick window or hysteresis thresholds
// [R11] High coarse: request bit 15, code 7..0
// [R12] Low coarse: request bit 15, code 7..0
// [R13] Force bit drives protection output active
// [R14] Polarity bit 1 makes output active-low
// [R15] Drive bit 1 selects open-drain, else push-pull
// [R16] Host writes reserved scan bits as zero
// [R17] Continuous bit repeats scans, else one scan
// [R18] Seven select bits each add one input
// [R19] No busy indication during continuous scanning
// [R20] Clearing continuous finishes the whole scan
// [R21] Host must drain results fast enough
// [R22] Continuous scanning only in clock modes 00, 01
// [R23] Continuous bit 7, selects 6..0, reset zero
// [R24] Load bits act once then clear themselves
module bccr_config_regs (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Command port from the serial front end
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [4:0]  i_cmd,
  input  wire logic [15:0] i_wr_data,
  output logic [15:0]      o_rd_data,
  output logic             o_rd_valid,
  // DAC side
  output logic [1:0][9:0]  o_fine_dac,
  output logic [1:0]       o_fine_cal_start,
  output logic [1:0][7:0]  o_coarse_high,
  output logic [1:0][7:0]  o_coarse_low,
  output logic [1:0]       o_high_cal_start,
  output logic [1:0]       o_low_cal_start,
  // Alarm configuration towards the threshold logic
  output logic             o_threshold_restore,
  output logic             o_alarm_comparator_sel,
  output logic [6:0]       o_hysteresis_lsbs,
  output logic [3:0]       o_meas_alarm_en,
  output logic [3:0]       o_meas_window_mode,
  // Alarm evaluation in, pins out
  input  wire logic [1:0]  i_protect_eval,
  input  wire logic        i_alarm_eval,
  output logic [1:0]       o_protect_out,
  output logic [1:0]       o_protect_oe,
  output logic             o_alarm_out,
  output logic             o_alarm_oe,
  // ADC scan sequencer
  input  wire logic [1:0]  i_adc_clk_mode,
  input  wire logic        i_ext_conv_start,
  input  wire logic        i_conv_done,
  output logic             o_conv_start,
  output logic [2:0]       o_conv_sel,
  output logic             o_adc_busy,
  // Amplifier offset calibration control
  input  wire logic        i_amp_cal_done,
  output logic [2:0]       o_amp_cal_ctrl
);

  // ==========================================================
  // Types and helpers
  // ==========================================================
  typedef enum logic [1:0] {SC_IDLE, SC_REQ, SC_WAIT} bccr_scan_t;

  // Lowest selected input at or above start; bit 3 flags found
  function automatic logic [3:0] bccr_next_sel(input logic [6:0] mask, input logic [2:0] start);
    logic [3:0] res;
    res = 4'h0;
    for (int i = bccr_pkg::NUM_SEL - 1; i >= 0; i--) begin
      if (mask[i] && (3'(i) >= start)) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  // ==========================================================
  // Storage
  // ==========================================================
  logic [1:0][9:0]  fine_in_r;      // Latest raw fine write
  logic [1:0][9:0]  fine_out_r;     // Fine DAC output code
  logic [1:0]       fine_cal_r;     // Calibration start pulses
  logic [1:0][15:0] coarse_hi_r;    // High wiper inputs
  logic [1:0][15:0] coarse_lo_r;    // Low wiper inputs
  logic [1:0][7:0]  coarse_hi_out_r;
  logic [1:0][7:0]  coarse_lo_out_r;
  logic [1:0]       hi_cal_r;
  logic [1:0]       lo_cal_r;
  logic [5:0]       load_r;         // Self-clearing load bits
  logic [10:0]      alarm_sw_r;
  logic             restore_r;
  logic [7:0]       alarm_hw_r;
  logic [7:0]       scan_r;
  logic [2:0]       amp_cal_r;
  logic [15:0]      rd_data_r;
  logic             rd_valid_r;
  logic [1:0]       prot_out_r;
  logic [1:0]       prot_oe_r;
  logic             alarm_out_r;
  logic             alarm_oe_r;
  bccr_scan_t       scan_state_r;
  logic [2:0]       scan_idx_r;
  logic             conv_start_r;
  logic             busy_r;

  // Write strobes per register
  logic wr_buf1, wr_buf2, wr_dir1, wr_dir2, wr_cal1, wr_cal2, wr_scan;
  assign wr_buf1 = i_wr_en && (i_cmd == bccr_pkg::CMD_FINE_BUF_CH1);
  assign wr_buf2 = i_wr_en && (i_cmd == bccr_pkg::CMD_FINE_BUF_CH2);
  assign wr_dir1 = i_wr_en && (i_cmd == bccr_pkg::CMD_FINE_DIR_CH1);
  assign wr_dir2 = i_wr_en && (i_cmd == bccr_pkg::CMD_FINE_DIR_CH2);
  assign wr_cal1 = i_wr_en && (i_cmd == bccr_pkg::CMD_FINE_CAL_CH1);
  assign wr_cal2 = i_wr_en && (i_cmd == bccr_pkg::CMD_FINE_CAL_CH2);
  assign wr_scan = i_wr_en && (i_cmd == bccr_pkg::CMD_ADC_SCAN);

  logic [1:0] wr_fine_any;
  logic [1:0] wr_fine_dir;
  logic [1:0] wr_fine_cal;
  assign wr_fine_any = {wr_buf2 | wr_dir2 | wr_cal2, wr_buf1 | wr_dir1 | wr_cal1};
  assign wr_fine_dir = {wr_dir2, wr_dir1};
  assign wr_fine_cal = {wr_cal2, wr_cal1};

  logic [1:0] ld_fine, ld_high, ld_low;
  assign ld_fine = {load_r[bccr_pkg::LD_FINE_CH2], load_r[bccr_pkg::LD_FINE_CH1]};
  assign ld_high = {load_r[bccr_pkg::LD_HIGH_CH2], load_r[bccr_pkg::LD_HIGH_CH1]};
  assign ld_low  = {load_r[bccr_pkg::LD_LOW_CH2], load_r[bccr_pkg::LD_LOW_CH1]};

  // ==========================================================
  // Fine DAC registers
  // ==========================================================
  // Input, output and cal pulse per channel
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fine_in_r  <= '0;  // R3
      fine_out_r <= '0;
      fine_cal_r <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        // Any fine write lands in the raw copy
        if (wr_fine_any[c]) begin
          fine_in_r[c] <= i_wr_data[bccr_pkg::FINE_W-1:0];  // R2 R4
        end
        // Direct write beats a load: it is newer
        if (wr_fine_dir[c]) begin
          fine_out_r[c] <= i_wr_data[bccr_pkg::FINE_W-1:0];  // R5
        end else if (ld_fine[c]) begin
          fine_out_r[c] <= fine_in_r[c];  // R1
        end
        // Only the calibrated write calibrates
        fine_cal_r[c] <= wr_fine_cal[c];  // R1 R5
      end
    end
  end

  // ==========================================================
  // Coarse wiper registers
  // ==========================================================
  // Keep request bit and code; bits 14..8 dropped
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      coarse_hi_r <= {2{bccr_pkg::COARSE_RST}};  // R11
      coarse_lo_r <= {2{bccr_pkg::COARSE_RST}};  // R12
    end else if (i_wr_en) begin
      for (int c = 0; c < 2; c++) begin
        if (i_cmd == (c == 0 ? bccr_pkg::CMD_COARSE_HI_CH1 : bccr_pkg::CMD_COARSE_HI_CH2)) begin
          coarse_hi_r[c] <= {i_wr_data[bccr_pkg::CAL_REQ_BIT], 7'h00,
                             i_wr_data[bccr_pkg::COARSE_W-1:0]};  // R11
        end
        if (i_cmd == (c == 0 ? bccr_pkg::CMD_COARSE_LO_CH1 : bccr_pkg::CMD_COARSE_LO_CH2)) begin
          coarse_lo_r[c] <= {i_wr_data[bccr_pkg::CAL_REQ_BIT], 7'h00,
                             i_wr_data[bccr_pkg::COARSE_W-1:0]};  // R12
        end
      end
    end
  end

  // Load moves the code, calibrates on request
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      coarse_hi_out_r <= '0;
      coarse_lo_out_r <= '0;
      hi_cal_r        <= '0;
      lo_cal_r        <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (ld_high[c]) begin
          coarse_hi_out_r[c] <= coarse_hi_r[c][bccr_pkg::COARSE_W-1:0];
        end
        if (ld_low[c]) begin
          coarse_lo_out_r[c] <= coarse_lo_r[c][bccr_pkg::COARSE_W-1:0];
        end
        hi_cal_r[c] <= ld_high[c] & coarse_hi_r[c][bccr_pkg::CAL_REQ_BIT];  // R11
        lo_cal_r[c] <= ld_low[c] & coarse_lo_r[c][bccr_pkg::CAL_REQ_BIT];   // R12
      end
    end
  end

  // ==========================================================
  // Software load register
  // ==========================================================
  // Written ones live one cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      load_r <= '0;
    end else if (i_wr_en && (i_cmd == bccr_pkg::CMD_DAC_LOAD)) begin
      load_r <= i_wr_data[bccr_pkg::LOAD_W-1:0];  // R24
    end else begin
      load_r <= '0;  // R24
    end
  end

  // ==========================================================
  // Alarm configuration
  // ==========================================================
  // Restore bit is an action, not state
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      alarm_sw_r <= '0;
      restore_r  <= 1'b0;
    end else begin
      restore_r <= 1'b0;
      if (i_wr_en && (i_cmd == bccr_pkg::CMD_ALARM_SW)) begin
        alarm_sw_r <= i_wr_data[bccr_pkg::ALARM_SW_W-1:0];  // R7 R9 R10
        restore_r  <= i_wr_data[bccr_pkg::THR_RESTORE_BIT];  // R6
      end
    end
  end

  // Hardware alarm configuration
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      alarm_hw_r <= '0;
    end else if (i_wr_en && (i_cmd == bccr_pkg::CMD_ALARM_HW)) begin
      alarm_hw_r <= i_wr_data[bccr_pkg::HW_CFG_W-1:0];
    end
  end

  // Pin stages: level, polarity, drive type
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prot_out_r  <= '0;
      prot_oe_r   <= '0;
      alarm_out_r <= 1'b0;
      alarm_oe_r  <= 1'b0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        logic act;
        logic lvl;
        logic od;
        act = i_protect_eval[c] | alarm_hw_r[c == 0 ? bccr_pkg::FORCE_CH1_BIT : bccr_pkg::FORCE_CH2_BIT];  // R13
        lvl = act ^ alarm_hw_r[c == 0 ? bccr_pkg::PROT1_POL_BIT : bccr_pkg::PROT2_POL_BIT];  // R14
        od  = alarm_hw_r[c == 0 ? bccr_pkg::PROT1_OD_BIT : bccr_pkg::PROT2_OD_BIT];
        // Open drain pulls low only, floats for high
        prot_out_r[c] <= od ? 1'b0 : lvl;  // R15
        prot_oe_r[c]  <= od ? ~lvl : 1'b1;  // R15
      end
      alarm_out_r <= alarm_hw_r[bccr_pkg::ALARM_OD_BIT] ? 1'b0
                   : (i_alarm_eval ^ alarm_hw_r[bccr_pkg::ALARM_POL_BIT]);  // R14 R15
      alarm_oe_r  <= alarm_hw_r[bccr_pkg::ALARM_OD_BIT]
                   ? ~(i_alarm_eval ^ alarm_hw_r[bccr_pkg::ALARM_POL_BIT]) : 1'b1;  // R15
    end
  end

  // ==========================================================
  // Amplifier calibration control
  // ==========================================================
  // Done clears trigger; a new write wins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      amp_cal_r <= '0;
    end else if (i_wr_en && (i_cmd == bccr_pkg::CMD_AMP_CAL)) begin
      amp_cal_r <= i_wr_data[bccr_pkg::AMP_CAL_W-1:0];
    end else if (i_amp_cal_done) begin
      amp_cal_r[bccr_pkg::AMP_TRIG_BIT] <= 1'b0;
    end
  end

  // ==========================================================
  // ADC scan control and sequencer
  // ==========================================================
  // Bits 15..8 are not stored
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      scan_r <= '0;  // R23
    end else if (wr_scan) begin
      scan_r <= i_wr_data[bccr_pkg::SCAN_W-1:0];  // R16 R23
    end
  end

  logic [6:0] sel_mask;
  logic       cont_ok;
  logic       scan_go;
  // A scan write starts from the new mask, not the stale one
  assign sel_mask = wr_scan ? i_wr_data[bccr_pkg::NUM_SEL-1:0] : scan_r[bccr_pkg::NUM_SEL-1:0];
  // No continuous repeat in modes 10 and 11
  assign cont_ok  = scan_r[bccr_pkg::CONT_BIT] & ~i_adc_clk_mode[1];  // R22
  // Mode 00 starts on a write, others while the external start input is high
  assign scan_go  = (i_adc_clk_mode == 2'h0) ? wr_scan : i_ext_conv_start;

  logic [3:0] first_sel;
  logic [3:0] after_sel;
  assign first_sel = bccr_next_sel(sel_mask, 3'h0);
  assign after_sel = (scan_idx_r == 3'h6) ? 4'h0 : bccr_next_sel(sel_mask, scan_idx_r + 3'h1);

  // Repeat is decided only at scan end, so a cleared
  // continuous bit lets the running scan finish
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      scan_state_r <= SC_IDLE;
      scan_idx_r   <= '0;
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      unique case (scan_state_r)
        SC_IDLE: begin
          if (scan_go && first_sel[3]) begin
            scan_idx_r   <= first_sel[2:0];  // R18
            scan_state_r <= SC_REQ;
          end
        end
        SC_REQ: begin
          conv_start_r <= 1'b1;
          scan_state_r <= SC_WAIT;
        end
        SC_WAIT: begin
          if (i_conv_done) begin
            if (after_sel[3]) begin
              scan_idx_r   <= after_sel[2:0];  // R18
              scan_state_r <= SC_REQ;
            end else if (cont_ok && first_sel[3]) begin
              scan_idx_r   <= first_sel[2:0];  // R17
              scan_state_r <= SC_REQ;
            end else begin
              scan_state_r <= SC_IDLE;  // R17 R20
            end
          end
        end
        default: scan_state_r <= SC_IDLE;
      endcase
    end
  end

  // Busy shows single scans only; the host must drain
  // the outside FIFO during continuous scans
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (scan_state_r != SC_IDLE) && !cont_ok;  // R19 R21
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  // Write-only and unknown codes read zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= i_rd_en;
      if (i_rd_en) begin
        unique case (i_cmd)
          bccr_pkg::CMD_ALARM_SW:      rd_data_r <= {5'h00, alarm_sw_r};
          bccr_pkg::CMD_COARSE_HI_CH1: rd_data_r <= coarse_hi_r[0];
          bccr_pkg::CMD_COARSE_HI_CH2: rd_data_r <= coarse_hi_r[1];
          bccr_pkg::CMD_COARSE_LO_CH1: rd_data_r <= coarse_lo_r[0];
          bccr_pkg::CMD_COARSE_LO_CH2: rd_data_r <= coarse_lo_r[1];
          bccr_pkg::CMD_ALARM_HW:      rd_data_r <= {8'h00, alarm_hw_r};
          bccr_pkg::CMD_FINE_RB_CH1:   rd_data_r <= {6'h00, fine_in_r[0]};  // R4
          bccr_pkg::CMD_FINE_RB_CH2:   rd_data_r <= {6'h00, fine_in_r[1]};  // R4
          default:                     rd_data_r <= bccr_pkg::ZERO_RST;
        endcase
      end
    end
  end

  // ==========================================================
  // Output wiring from flops
  // ==========================================================
  assign o_rd_data              = rd_data_r;
  assign o_rd_valid             = rd_valid_r;
  assign o_fine_dac             = fine_out_r;
  assign o_fine_cal_start       = fine_cal_r;
  assign o_coarse_high          = coarse_hi_out_r;
  assign o_coarse_low           = coarse_lo_out_r;
  assign o_high_cal_start       = hi_cal_r;
  assign o_low_cal_start        = lo_cal_r;
  assign o_threshold_restore    = restore_r;
  assign o_alarm_comparator_sel = alarm_sw_r[bccr_pkg::CMP_SEL_BIT];
  // One-hot size: bit 3 = 8 LSBs up to bit 6 = 64
  assign o_hysteresis_lsbs      = 7'h08 << alarm_sw_r[bccr_pkg::HYST_MSB:bccr_pkg::HYST_LSB];  // R8
  assign o_meas_alarm_en        = {alarm_sw_r[7], alarm_sw_r[5], alarm_sw_r[3], alarm_sw_r[1]};  // R9
  assign o_meas_window_mode     = {alarm_sw_r[6], alarm_sw_r[4], alarm_sw_r[2], alarm_sw_r[0]};  // R10
  assign o_protect_out          = prot_out_r;
  assign o_protect_oe           = prot_oe_r;
  assign o_alarm_out            = alarm_out_r;
  assign o_alarm_oe             = alarm_oe_r;
  assign o_conv_start           = conv_start_r;
  assign o_conv_sel             = scan_idx_r;
  assign o_adc_busy             = busy_r;
  assign o_amp_cal_ctrl         = amp_cal_r;

endmodule

// File: verilog/bccr_pkg.sv
package bccr_pkg;
  // ==========================================================
  // Command codes selecting a register on the command port
  // ==========================================================
  localparam logic [4:0] CMD_ALARM_SW      = 5'h00;
  localparam logic [4:0] CMD_COARSE_HI_CH1 = 5'h01;
  localparam logic [4:0] CMD_COARSE_HI_CH2 = 5'h02;
  localparam logic [4:0] CMD_COARSE_LO_CH1 = 5'h03;
  localparam logic [4:0] CMD_COARSE_LO_CH2 = 5'h04;
  localparam logic [4:0] CMD_FINE_CAL_CH1  = 5'h05;
  localparam logic [4:0] CMD_FINE_CAL_CH2  = 5'h06;
  localparam logic [4:0] CMD_AMP_CAL       = 5'h07;
  localparam logic [4:0] CMD_FINE_BUF_CH1  = 5'h08;
  localparam logic [4:0] CMD_FINE_BUF_CH2  = 5'h09;
  localparam logic [4:0] CMD_FINE_DIR_CH1  = 5'h0a;
  localparam logic [4:0] CMD_FINE_DIR_CH2  = 5'h0b;
  localparam logic [4:0] CMD_ALARM_HW      = 5'h0c;
  localparam logic [4:0] CMD_ADC_SCAN      = 5'h0d;
  localparam logic [4:0] CMD_DAC_LOAD      = 5'h0e;
  localparam logic [4:0] CMD_FINE_RB_CH1   = 5'h0f;
  localparam logic [4:0] CMD_FINE_RB_CH2   = 5'h10;

  // ==========================================================
  // Field layout
  // ==========================================================
  localparam int FINE_W          = 10;  // Fine code width, low bits
  localparam int COARSE_W        = 8;   // Coarse code width, low bits
  localparam int CAL_REQ_BIT     = 15;  // Coarse calibration request
  localparam int THR_RESTORE_BIT = 11;  // Threshold restore (action)
  localparam int ALARM_SW_W      = 11;  // Stored bits 10..0
  localparam int CMP_SEL_BIT     = 10;
  localparam int HYST_MSB        = 9;
  localparam int HYST_LSB        = 8;
  localparam int HW_CFG_W        = 8;
  localparam int FORCE_CH1_BIT   = 7;
  localparam int FORCE_CH2_BIT   = 6;
  localparam int ALARM_POL_BIT   = 5;
  localparam int ALARM_OD_BIT    = 4;
  localparam int PROT1_POL_BIT   = 3;
  localparam int PROT1_OD_BIT    = 2;
  localparam int PROT2_POL_BIT   = 1;
  localparam int PROT2_OD_BIT    = 0;
  localparam int SCAN_W          = 8;
  localparam int CONT_BIT        = 7;   // Select bits are 6..0
  localparam int NUM_SEL         = 7;
  localparam int AMP_CAL_W       = 3;   // Tracking, trigger, periodic
  localparam int AMP_TRACK_BIT   = 2;
  localparam int AMP_TRIG_BIT    = 1;
  localparam int AMP_PERIOD_BIT  = 0;
  // Load register bits: fine/high/low for ch2 then ch1
  localparam int LD_FINE_CH2     = 5;
  localparam int LD_HIGH_CH2     = 4;
  localparam int LD_LOW_CH2      = 3;
  localparam int LD_FINE_CH1     = 2;
  localparam int LD_HIGH_CH1     = 1;
  localparam int LD_LOW_CH1      = 0;
  localparam int LOAD_W          = 6;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [15:0] COARSE_RST = 16'h8000;  // Request set, code 0
  localparam logic [15:0] ZERO_RST   = 16'h0000;
endpackage
